// [core/lcps_pkg.sv]
// Constants and types shared by the LCD common pin select block
// How it works
// - Line 5 LCD only at duty 1/5..1/16
// - Line 6 LCD only at duty 1/6..1/16
// - Line 7 LCD only at duty 1/7..1/16
// - Line 8 LCD only at duty 1/8..1/16
// - Line 9 LCD only at duty 1/9..1/16
// - Line 10 LCD only at duty 1/10..1/16
// - Line 11 LCD only at duty 1/11..1/16
// - Line 12 LCD only at duty 1/12..1/16
// - Line 13 LCD only at duty 1/13..1/16
// - Line 14 general use is push-pull only
// - Line 15 LCD only at duty 1/15..1/16
// - Line 16 LCD only at duty 1/16
// - Program memory split in half-K steps
package lcps_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int LCPS_LINES = 12;
    localparam int LCPS_DUTY_W = 5;
    localparam int LCPS_MEM_W = 6;
    // ------------------------------------------------------------
    // Line numbering and duty limits
    // ------------------------------------------------------------
    localparam logic [4:0] LCPS_FIRST_LINE = 5'h05;
    localparam logic [4:0] LCPS_DUTY_MIN = 5'h04;
    localparam logic [4:0] LCPS_DUTY_MAX = 5'h10;
    // ------------------------------------------------------------
    // Role encodings, two bits per line
    // ------------------------------------------------------------
    localparam logic [1:0] LCPS_ROLE_LCD = 2'h0;
    localparam logic [1:0] LCPS_ROLE_PP = 2'h1;
    localparam logic [1:0] LCPS_ROLE_OD = 2'h2;
    // Lines on which open-drain is offered; line 14 (bit 9) has none
    localparam logic [11:0] LCPS_OD_OK = 12'hdff;
    // ------------------------------------------------------------
    // Memory split
    // ------------------------------------------------------------
    localparam logic [5:0] LCPS_MEM_STEPS = 6'h20;
    localparam logic [6:0] LCPS_INSTR_BASE_HALFK = 7'h20;
    localparam logic [5:0] LCPS_TABLE_MAX_KB = 6'h20;
    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [11:0] LCPS_RST_LINES = 12'h000;
    localparam logic [23:0] LCPS_RST_ROLES = 24'h000000;
    localparam logic [4:0] LCPS_RST_DUTY = 5'h00;
    localparam logic [5:0] LCPS_RST_MEM = 6'h00;
    localparam logic [6:0] LCPS_RST_INSTR = 7'h00;
    // ------------------------------------------------------------
    // Configuration sequencer
    // ------------------------------------------------------------
    typedef enum {LCPS_CAPTURE, LCPS_CHECK, LCPS_RUN} lcps_state_t;
endpackage : lcps_pkg

// [core/lcps_pin_cell.sv]
// One output line: drives LCD common, push-pull or open-drain output
`timescale 1ns/100ps
module lcps_pin_cell (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic en_i,
    input wire logic [1:0] role_i,
    input wire logic gp_data_i,
    input wire logic lcd_data_i,
    output logic pin_o,
    output logic pin_oe_o
);
    import lcps_pkg::*;

    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;

    // ------------------------------------------------------------
    // Drive selection
    // ------------------------------------------------------------
    always_comb begin
        out_next = 1'b0;
        oe_next = 1'b0;
        if (en_i) begin
            case (role_i)
                LCPS_ROLE_LCD: begin
                    out_next = lcd_data_i;
                    oe_next = 1'b1;
                end
                LCPS_ROLE_PP: begin
                    out_next = gp_data_i;
                    oe_next = 1'b1;
                end
                LCPS_ROLE_OD: begin
                    // Only the high level is driven, low lets the pin float
                    out_next = gp_data_i;
                    oe_next = gp_data_i;
                end
                default: begin
                    out_next = 1'b0;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign pin_o = out_reg;
    assign pin_oe_o = oe_reg;
endmodule : lcps_pin_cell

// [core/lcps_top.sv]
// LCD common pin select: role of lines 5..16 and program memory split
`timescale 1ns/100ps
module lcps_top #(
    parameter int LINES = lcps_pkg::LCPS_LINES
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [lcps_pkg::LCPS_DUTY_W-1:0] DUTY_I,
    input wire logic [2*LINES-1:0] ROLE_SEL_I,
    input wire logic [lcps_pkg::LCPS_MEM_W-1:0] MEM_SPLIT_I,
    input wire logic [LINES-1:0] GP_DATA_I,
    input wire logic [LINES-1:0] LCD_COM_I,
    output logic [LINES-1:0] PIN_O,
    output logic [LINES-1:0] PIN_OE_O,
    output logic [LINES-1:0] LINE_LCD_O,
    output logic [LINES-1:0] LINE_FAULT_O,
    output logic DUTY_FAULT_O,
    output logic MEM_FAULT_O,
    output logic CFG_ERROR_O,
    output logic CFG_READY_O,
    output logic CFG_CHANGED_O,
    output logic [6:0] INSTR_HALFK_O,
    output logic [5:0] TABLE_KBYTES_O
);
    import lcps_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // True when a line may carry the LCD common signal at a duty
    function automatic logic lcd_allowed(
        input logic [4:0] line_num,
        input logic [4:0] duty
    );
        return (duty >= line_num);
    endfunction : lcd_allowed

    // True when a line is left free for general output at a duty
    function automatic logic general_allowed(
        input logic [4:0] line_num,
        input logic [4:0] duty
    );
        return (duty < line_num);
    endfunction : general_allowed

    // True when a role is allowed on a line at a duty
    function automatic logic role_ok(
        input logic [4:0] line_num,
        input logic [4:0] duty,
        input logic [1:0] role,
        input logic od_offered
    );
        logic ok;
        ok = 1'b0;
        case (role)
            LCPS_ROLE_LCD: ok = lcd_allowed(line_num, duty);
            LCPS_ROLE_PP: ok = general_allowed(line_num, duty);
            LCPS_ROLE_OD: ok = general_allowed(line_num, duty) && od_offered;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : role_ok

    // True when a duty denominator is one that the LCD driver offers
    function automatic logic duty_ok(input logic [4:0] duty);
        return (duty >= LCPS_DUTY_MIN) && (duty <= LCPS_DUTY_MAX);
    endfunction : duty_ok

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lcps_state_t state_reg;
    lcps_state_t state_next;
    logic [4:0] duty_reg;
    logic [2*LINES-1:0] role_reg;
    logic [5:0] mem_reg;
    logic [LINES-1:0] fault_reg;
    logic [LINES-1:0] lcd_reg;
    logic duty_fault_reg;
    logic mem_fault_reg;
    logic changed_reg;
    logic [6:0] instr_reg;
    logic [5:0] table_reg;

    // ------------------------------------------------------------
    // Decoding of the held configuration
    // ------------------------------------------------------------
    wire capture_en = (state_reg == LCPS_CAPTURE);
    wire check_en = (state_reg == LCPS_CHECK);
    wire run_en = (state_reg == LCPS_RUN);
    wire duty_bad = !duty_ok(duty_reg);
    wire mem_bad = (mem_reg > LCPS_MEM_STEPS);
    wire [LINES-1:0] line_bad;
    wire [LINES-1:0] line_lcd;
    wire [LINES-1:0] line_en;
    // Any duty, role or split input that moves after capture is noted, never applied
    wire cfg_moved = (DUTY_I != duty_reg) || (ROLE_SEL_I != role_reg)
        || (MEM_SPLIT_I != mem_reg);
    wire [6:0] instr_calc = LCPS_INSTR_BASE_HALFK + {1'b0, mem_reg};
    wire [5:0] table_calc = LCPS_TABLE_MAX_KB - mem_reg;

    // Line i is common line LCPS_FIRST_LINE+i; each one shares the same test
    // Index 0, line 5
    // Index 1, line 6
    // Index 2, line 7
    // Index 3, line 8
    // Index 4, line 9
    // Index 5, line 10
    // Index 6, line 11
    // Index 7, line 12
    // Index 8, line 13
    // Index 9, line 14, general use without open-drain
    // Index 10, line 15
    // Index 11, line 16
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            localparam logic [4:0] LINE_NUM = LCPS_FIRST_LINE + 5'(gi);
            wire [1:0] role_w = role_reg[2*gi +: 2];
            // Line 14 has no open-drain option at all
            assign line_bad[gi] = duty_bad
                || !role_ok(LINE_NUM, duty_reg, role_w, LCPS_OD_OK[gi]);
            assign line_lcd[gi] = (role_w == LCPS_ROLE_LCD);
            // A rejected line floats rather than fight the panel
            assign line_en[gi] = run_en && !fault_reg[gi];

            lcps_pin_cell lcps_pin_cell_i (
                .CLK_I(CLK_I),
                .RST_N_I(RST_N_I),
                .en_i(line_en[gi]),
                .role_i(role_w),
                .gp_data_i(GP_DATA_I[gi]),
                .lcd_data_i(LCD_COM_I[gi]),
                .pin_o(PIN_O[gi]),
                .pin_oe_o(PIN_OE_O[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Configuration sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LCPS_CAPTURE: state_next = LCPS_CHECK;
            LCPS_CHECK: state_next = LCPS_RUN;
            LCPS_RUN: state_next = LCPS_RUN;
            default: state_next = LCPS_CAPTURE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= LCPS_CAPTURE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Capture once after reset, then hold
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            duty_reg <= LCPS_RST_DUTY;
            role_reg <= LCPS_RST_ROLES;
            mem_reg <= LCPS_RST_MEM;
        end else if (capture_en) begin
            duty_reg <= DUTY_I;
            role_reg <= ROLE_SEL_I;
            mem_reg <= MEM_SPLIT_I;
        end
    end

    // ------------------------------------------------------------
    // Check results
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fault_reg <= LCPS_RST_LINES;
            lcd_reg <= LCPS_RST_LINES;
            duty_fault_reg <= 1'b0;
            mem_fault_reg <= 1'b0;
        end else if (check_en) begin
            fault_reg <= line_bad;
            lcd_reg <= line_lcd & ~line_bad;
            duty_fault_reg <= duty_bad;
            mem_fault_reg <= mem_bad;
        end
    end

    // ------------------------------------------------------------
    // Memory split
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            instr_reg <= LCPS_RST_INSTR;
            table_reg <= LCPS_RST_MEM;
        end else if (check_en) begin
            // A rejected split publishes nothing
            instr_reg <= mem_bad ? LCPS_RST_INSTR : instr_calc;
            table_reg <= mem_bad ? LCPS_RST_MEM : table_calc;
        end
    end

    // ------------------------------------------------------------
    // Run-time change monitor
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            changed_reg <= 1'b0;
        end else if (!capture_en && cfg_moved) begin
            changed_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    assign LINE_FAULT_O = fault_reg;
    assign LINE_LCD_O = lcd_reg;
    assign DUTY_FAULT_O = duty_fault_reg;
    assign MEM_FAULT_O = mem_fault_reg;
    assign CFG_ERROR_O = duty_fault_reg || mem_fault_reg || (|fault_reg);
    assign CFG_READY_O = run_en;
    assign CFG_CHANGED_O = changed_reg;
    assign INSTR_HALFK_O = instr_reg;
    assign TABLE_KBYTES_O = table_reg;
endmodule : lcps_top

// [tb/lcps_properties.sv]
// Port checker for the LCD common pin select block
`timescale 1ns/100ps
module lcps_checker #(
    parameter int LINES = 12
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [4:0] DUTY_I,
    input wire logic [2*LINES-1:0] ROLE_SEL_I,
    input wire logic [5:0] MEM_SPLIT_I,
    input wire logic [LINES-1:0] GP_DATA_I,
    input wire logic [LINES-1:0] LCD_COM_I,
    input wire logic [LINES-1:0] PIN_O,
    input wire logic [LINES-1:0] PIN_OE_O,
    input wire logic [LINES-1:0] LINE_LCD_O,
    input wire logic [LINES-1:0] LINE_FAULT_O,
    input wire logic DUTY_FAULT_O,
    input wire logic MEM_FAULT_O,
    input wire logic CFG_ERROR_O,
    input wire logic CFG_READY_O,
    input wire logic CFG_CHANGED_O,
    input wire logic [6:0] INSTR_HALFK_O,
    input wire logic [5:0] TABLE_KBYTES_O
);
    import lcps_pkg::*;
    logic [LINES-1:0] e_lcd, e_pp, e_od, e_flt;
    logic bad, run;
    assign bad = (DUTY_I < LCPS_DUTY_MIN) || (DUTY_I > LCPS_DUTY_MAX);
    assign run = CFG_READY_O && !CFG_CHANGED_O;
    for (genvar i = 0; i < LINES; i++) begin : g_line
        logic hi;
        assign hi = DUTY_I >= 5'(i + 5);
        assign e_lcd[i] = !bad && ROLE_SEL_I[2*i +: 2] == LCPS_ROLE_LCD && hi;
        assign e_pp[i] = !bad && ROLE_SEL_I[2*i +: 2] == LCPS_ROLE_PP && !hi;
        assign e_od[i] = !bad && ROLE_SEL_I[2*i +: 2] == LCPS_ROLE_OD && !hi && LCPS_OD_OK[i];
        assign e_flt[i] = !(e_lcd[i] || e_pp[i] || e_od[i]);
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    chk_line_roles: assert property (run && $stable(DUTY_I) && $stable(ROLE_SEL_I)
        |-> LINE_LCD_O == e_lcd && LINE_FAULT_O == e_flt) else $error("line roles wrong");
    chk_duty_range: assert property (run && $stable(DUTY_I) |-> DUTY_FAULT_O == bad)
        else $error("duty fault wrong");
    chk_mem_sizes: assert property (run && $stable(MEM_SPLIT_I) && MEM_SPLIT_I <= 6'h20
        |-> !MEM_FAULT_O && INSTR_HALFK_O == 7'h20 + MEM_SPLIT_I
        && TABLE_KBYTES_O == 6'h20 - MEM_SPLIT_I) else $error("memory split wrong");
    chk_mem_reject: assert property (run && $stable(MEM_SPLIT_I) && MEM_SPLIT_I > 6'h20
        |-> MEM_FAULT_O && INSTR_HALFK_O == 7'h00 && TABLE_KBYTES_O == 6'h00)
        else $error("bad split accepted");
    chk_lcd_drive: assert property (run && $past(CFG_READY_O)
        && $stable(DUTY_I) && $stable(ROLE_SEL_I)
        |-> ((PIN_O ^ $past(LCD_COM_I)) & e_lcd) == 0 && (PIN_OE_O & e_lcd) == e_lcd)
        else $error("lcd line not driven");
    chk_pp_drive: assert property (run && $past(CFG_READY_O)
        && $stable(DUTY_I) && $stable(ROLE_SEL_I)
        |-> ((PIN_O ^ $past(GP_DATA_I)) & e_pp) == 0 && (PIN_OE_O & e_pp) == e_pp)
        else $error("push-pull line wrong");
    chk_od_drive: assert property (run && $past(CFG_READY_O)
        && $stable(DUTY_I) && $stable(ROLE_SEL_I)
        |-> (((PIN_O ^ $past(GP_DATA_I)) | (PIN_OE_O ^ $past(GP_DATA_I))) & e_od) == 0)
        else $error("open-drain line wrong");
    chk_fault_float: assert property ((LINE_FAULT_O & (PIN_O | PIN_OE_O)) == 0)
        else $error("faulted line driven");
    chk_ready_time: assert property ($rose(RST_N_I) |-> ##1 !CFG_READY_O ##1 CFG_READY_O)
        else $error("ready timing wrong");
    chk_change_flag: assert property (CFG_READY_O && !$stable(DUTY_I) |=> CFG_CHANGED_O)
        else $error("change not flagged");
    chk_change_hold: assert property (CFG_CHANGED_O |=> CFG_CHANGED_O)
        else $error("change flag dropped");
    cover property (run && (|e_od));
    cover property (CFG_CHANGED_O);
    cover property (MEM_FAULT_O);
endmodule : lcps_checker

bind lcps_top lcps_checker #(.LINES(LINES)) lcps_checker_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .DUTY_I(DUTY_I), .ROLE_SEL_I(ROLE_SEL_I), .MEM_SPLIT_I(MEM_SPLIT_I), .GP_DATA_I(GP_DATA_I),
    .LCD_COM_I(LCD_COM_I), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .LINE_LCD_O(LINE_LCD_O),
    .LINE_FAULT_O(LINE_FAULT_O), .DUTY_FAULT_O(DUTY_FAULT_O), .MEM_FAULT_O(MEM_FAULT_O),
    .CFG_ERROR_O(CFG_ERROR_O), .CFG_READY_O(CFG_READY_O), .CFG_CHANGED_O(CFG_CHANGED_O),
    .INSTR_HALFK_O(INSTR_HALFK_O), .TABLE_KBYTES_O(TABLE_KBYTES_O));

// [tb/lcps_panel_model.sv]
// Far-side loads on the common lines: level seen on each wire
`timescale 1ns/100ps
module lcps_panel_model #(
    parameter int LINES = 12
) (
    input wire logic clk_i,
    input wire logic [LINES-1:0] pin_i,
    input wire logic [LINES-1:0] oe_i,
    output logic [LINES-1:0] level_o
);
    logic [LINES-1:0] last_reg = '0;
    // No pull on the wire: a floating line toggles every cycle
    assign level_o = (oe_i & pin_i) | (~oe_i & ~last_reg);
    always_ff @(posedge clk_i) begin
        last_reg <= level_o;
    end
endmodule : lcps_panel_model

// [tb/lcps_top_test.sv]
// Self-checking bench for the LCD common pin select block
`timescale 1ns/100ps
module lcps_top_test;
    import lcps_pkg::*;
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic [4:0] DUTY_I = 5'h04;
    logic [23:0] ROLE_SEL_I = 24'h000000;
    logic [5:0] MEM_SPLIT_I = 6'h00;
    logic [11:0] GP_DATA_I = 12'h000;
    logic [11:0] LCD_COM_I = 12'h000;
    logic [11:0] PIN_O, PIN_OE_O, LINE_LCD_O, LINE_FAULT_O, level;
    logic DUTY_FAULT_O, MEM_FAULT_O, CFG_ERROR_O, CFG_READY_O, CFG_CHANGED_O;
    logic [6:0] INSTR_HALFK_O;
    logic [5:0] TABLE_KBYTES_O;
    int n_errors = 0;
    int check_count = 0;
    lcps_top lcps_top_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .DUTY_I(DUTY_I),
        .ROLE_SEL_I(ROLE_SEL_I), .MEM_SPLIT_I(MEM_SPLIT_I), .GP_DATA_I(GP_DATA_I),
        .LCD_COM_I(LCD_COM_I), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .LINE_LCD_O(LINE_LCD_O),
        .LINE_FAULT_O(LINE_FAULT_O), .DUTY_FAULT_O(DUTY_FAULT_O), .MEM_FAULT_O(MEM_FAULT_O),
        .CFG_ERROR_O(CFG_ERROR_O), .CFG_READY_O(CFG_READY_O), .CFG_CHANGED_O(CFG_CHANGED_O),
        .INSTR_HALFK_O(INSTR_HALFK_O), .TABLE_KBYTES_O(TABLE_KBYTES_O));
    lcps_panel_model lcps_panel_model_i (.clk_i(CLK_I), .pin_i(PIN_O), .oe_i(PIN_OE_O),
        .level_o(level));
    initial begin
        forever #4 CLK_I = ~CLK_I;
    end
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cfg(input logic [4:0] d, input logic [23:0] r, input logic [5:0] m);
        @(posedge CLK_I);
        RST_N_I <= 1'b0;
        DUTY_I <= d;
        ROLE_SEL_I <= r;
        MEM_SPLIT_I <= m;
        repeat (16) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        #1;
    endtask : cfg
    task automatic drive(input logic [11:0] gp, input logic [11:0] lc);
        @(posedge CLK_I);
        GP_DATA_I <= gp;
        LCD_COM_I <= lc;
        @(posedge CLK_I);
        #1;
    endtask : drive
    // Duty 1/4: push-pull and open-drain mix, line 14 push-pull only
    task automatic test_general;
        logic [11:0] v [3] = '{12'hfff, 12'h000, 12'ha5c};
        cfg(5'h04, 24'h959999, 6'h00);
        check("fault", LINE_FAULT_O, 12'h000);
        check("error", CFG_ERROR_O, 12'h000);
        foreach (v[j]) begin
            drive(v[j], ~v[j]);
            check("oe", PIN_OE_O, 12'h755 | (12'h8aa & v[j]));
            check("pin", PIN_O, v[j]);
            check("wire", level & (12'h755 | v[j]), v[j]);
        end
    endtask : test_general
    // Every duty and role code, just outside the legal range too
    task automatic test_duty;
        logic [11:0] e;
        logic bad;
        for (int d = 3; d <= 17; d++) begin
            for (int k = 0; k < 4; k++) begin
                bad = d < 4 || d > 16;
                cfg(5'(d), {12{2'(k)}}, 6'h00);
                for (int i = 0; i < 12; i++) begin
                    e[i] = bad || k == 3 || (k == 0 ? d < i + 5 : d >= i + 5 || (k == 2 && i == 9));
                end
                check("line fault", LINE_FAULT_O, e);
                check("line lcd", LINE_LCD_O, k == 0 ? ~e : 12'h000);
                check("duty fault", DUTY_FAULT_O, bad);
                check("cfg error", CFG_ERROR_O, |e);
            end
        end
    endtask : test_duty
    // Duty 1/16, all lines LCD
    task automatic test_lcd;
        cfg(5'h10, 24'h000000, 6'h20);
        drive(12'h0f0, 12'h3c5);
        check("lcd pin", PIN_O, 12'h3c5);
        check("lcd oe", PIN_OE_O, 12'hfff);
    endtask : test_lcd
    // All split codes and the first one beyond
    task automatic test_mem;
        for (int c = 0; c <= 33; c++) begin
            cfg(5'h10, 24'h000000, 6'(c));
            check("instr", INSTR_HALFK_O, c <= 32 ? 12'(32 + c) : 12'h000);
            check("table", TABLE_KBYTES_O, c <= 32 ? 12'(32 - c) : 12'h000);
            check("mem fault", MEM_FAULT_O, c > 32);
            check("mem error", CFG_ERROR_O, c > 32);
        end
    endtask : test_mem
    // Change after capture is flagged and ignored
    task automatic test_refuse;
        cfg(5'h08, 24'h000000, 6'h04);
        @(posedge CLK_I);
        DUTY_I <= 5'h10;
        ROLE_SEL_I <= 24'h555555;
        repeat (3) @(posedge CLK_I);
        #1;
        check("changed", CFG_CHANGED_O, 12'h001);
        check("held lcd", LINE_LCD_O, 12'h00f);
        check("held instr", INSTR_HALFK_O, 12'h024);
    endtask : test_refuse
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial begin
        test_general();
        test_duty();
        test_lcd();
        test_mem();
        test_refuse();
        finish_test();
    end
endmodule : lcps_top_test
